/* File: core/baud_gen_regs.svh */
// register offsets, field positions, reset values and counts of the baud tick divider
`ifndef BAUD_GEN_REGS_SVH
`define BAUD_GEN_REGS_SVH

`define ADDR_TRANSMIT_STATUS_CONTROL 3'h0
`define ADDR_RECEIVE_STATUS_CONTROL 3'h1
`define ADDR_BAUD_RATE_CONTROL 3'h2
`define ADDR_BAUD_DIVISOR_HIGH 3'h3
`define ADDR_BAUD_DIVISOR_LOW 3'h4
`define ADDR_SAMPLER_STATUS 3'h5

`define BIT_CLOCKED_MODE_SELECT 4
`define BIT_HIGH_SPEED_SELECT 2
`define BIT_TRANSMIT_SHIFT_EMPTY 1
`define BIT_WIDE_DIVISOR_SELECT 3
`define BIT_RECEIVE_IDLE 6
`define BIT_SERIAL_PORT_ENABLE 7
`define BIT_STATUS_LEVEL 0
`define BIT_STATUS_SINGLE 1

`define RESET_TRANSMIT_STATUS_CONTROL 8'h02
`define RESET_RECEIVE_STATUS_CONTROL 8'h00
`define RESET_BAUD_RATE_CONTROL 8'h40
`define RESET_BAUD_DIVISOR 8'h00

`define MASK_TRANSMIT_STATUS_CONTROL 8'hfd
`define MASK_RECEIVE_STATUS_CONTROL 8'hf8
`define MASK_BAUD_RATE_CONTROL 8'hbb

`define PRESCALE_SLOW 7'h40
`define PRESCALE_FAST 7'h10
`define PRESCALE_CLOCKED 7'h04

`endif

/* File: core/baud_gen_pkg.sv */
// types shared by the baud tick divider and its receive-line sampler
package baud_gen_pkg;

  typedef struct packed {
    logic write;
    logic read;
    logic [2:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic valid;
    logic level;
  } rx_bit_s;

  typedef enum logic [2:0] {
    MODE_DIV64 = 3'b001,
    MODE_DIV16 = 3'b010,
    MODE_DIV4 = 3'b100
  } baud_mode_e;

endpackage

/* File: core/rx_sampler.sv */
// receive-line synchroniser with single sample or three-sample majority vote
`timescale 1ns/1ps
module rx_sampler
  import baud_gen_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic rx_pin_i,
  input wire logic sample_i,
  input wire logic last_i,
  input wire logic single_i,
  output rx_bit_s rx_bit_o
);

  logic sync1_reg;
  logic sync2_reg;
  logic [2:0] samples_reg;
  logic decide_reg;
  rx_bit_s rx_bit_reg;
  wire logic voted;

  function automatic logic majority3(input logic [2:0] s);
    majority3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  assign voted = single_i ? samples_reg[0] : majority3(samples_reg);

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      samples_reg <= 3'h7;
      decide_reg <= 1'b0;
      rx_bit_reg <= '0;
    end else begin
      sync1_reg <= rx_pin_i;
      sync2_reg <= sync1_reg;
      if (sample_i) begin
        samples_reg <= {samples_reg[1:0], sync2_reg};
      end
      decide_reg <= last_i;
      rx_bit_reg.valid <= decide_reg;
      if (decide_reg) begin
        rx_bit_reg.level <= voted;
      end
    end
  end

  assign rx_bit_o = rx_bit_reg;

endmodule

/* File: core/serial_baud_rate_generator.sv */
// baud tick divider, prescaler, receive sampling strobes and control registers
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "baud_gen_regs.svh"
module serial_baud_rate_generator
  import baud_gen_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  input reg_req_s reg_req_i,
  output logic [7:0] reg_rdata_o,
  input wire logic rx_pin_i,
  output logic divider_tick_o,
  output logic bit_tick_o,
  output logic clocked_mode_o,
  output logic serial_enable_o,
  output rx_bit_s rx_bit_o
);

  logic [7:0] transmit_status_control_reg;
  logic [7:0] receive_status_control_reg;
  logic [7:0] baud_rate_control_reg;
  logic [7:0] divisor_high_byte_reg;
  logic [7:0] divisor_low_byte_reg;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [6:0] phase_reg;
  logic [6:0] phase_next;
  logic [7:0] rdata_reg;

  wire logic wr_tx;
  wire logic wr_rx;
  wire logic wr_baud;
  wire logic wr_high;
  wire logic wr_low;
  wire logic reload;
  wire logic clocked_mode_select;
  wire logic high_speed_select;
  wire logic wide_divisor_select;
  wire logic single_sample;
  wire logic [7:0] high_after;
  wire logic [7:0] low_after;
  wire logic [15:0] divisor_now;
  wire logic [15:0] divisor_after;
  wire logic tick;
  wire logic [6:0] prescale;
  wire logic [6:0] mid;
  wire logic sample_strobe;
  wire logic last_strobe;
  wire logic [7:0] status_word;
  wire logic [7:0] read_mux;
  baud_mode_e mode;

  // high byte above low byte; low byte only unless widened
  function automatic logic [15:0] divisor_of(input logic wide,
                                             input logic [7:0] hi,
                                             input logic [7:0] lo);
    divisor_of = wide ? {hi, lo} : {8'h00, lo};
  endfunction

  function automatic logic [6:0] prescale_of(input baud_mode_e m);
    logic [6:0] p;
    p = `PRESCALE_SLOW;
    unique case (m)
      MODE_DIV64: begin
        p = `PRESCALE_SLOW;
      end
      MODE_DIV16: begin
        p = `PRESCALE_FAST;
      end
      MODE_DIV4: begin
        p = `PRESCALE_CLOCKED;
      end
    endcase
    prescale_of = p;
  endfunction

  // register decode
  assign wr_tx = reg_req_i.write && (reg_req_i.addr == `ADDR_TRANSMIT_STATUS_CONTROL);
  assign wr_rx = reg_req_i.write && (reg_req_i.addr == `ADDR_RECEIVE_STATUS_CONTROL);
  assign wr_baud = reg_req_i.write && (reg_req_i.addr == `ADDR_BAUD_RATE_CONTROL);
  assign wr_high = reg_req_i.write && (reg_req_i.addr == `ADDR_BAUD_DIVISOR_HIGH);
  assign wr_low = reg_req_i.write && (reg_req_i.addr == `ADDR_BAUD_DIVISOR_LOW);

  assign reload = wr_high || wr_low;

  // mode selects in the transmit control register
  assign clocked_mode_select = transmit_status_control_reg[`BIT_CLOCKED_MODE_SELECT];
  assign high_speed_select = transmit_status_control_reg[`BIT_HIGH_SPEED_SELECT];
  // wide select in the baud control register
  assign wide_divisor_select = baud_rate_control_reg[`BIT_WIDE_DIVISOR_SELECT];

  // clocked mode ignores the high-speed select
  // wide plus high speed asynchronous shares the divide-by-4 path
  assign mode = clocked_mode_select ? MODE_DIV4 :
                (wide_divisor_select && high_speed_select) ? MODE_DIV4 :
                (wide_divisor_select || high_speed_select) ? MODE_DIV16 :
                MODE_DIV64;

  // single sample in clocked mode or wide plus high speed
  assign single_sample = clocked_mode_select || (wide_divisor_select && high_speed_select);

  assign prescale = prescale_of(mode);
  assign mid = {1'b0, prescale[6:1]};

  // the reload uses the byte being written, so the new rate starts at once
  assign high_after = wr_high ? reg_req_i.wdata : divisor_high_byte_reg;
  assign low_after = wr_low ? reg_req_i.wdata : divisor_low_byte_reg;
  assign divisor_now = divisor_of(wide_divisor_select, divisor_high_byte_reg,
                                  divisor_low_byte_reg);
  assign divisor_after = divisor_of(wide_divisor_select, high_after, low_after);

  // counts raw system clock cycles, no enable
  assign tick = (count_reg == 16'h0000) && !reload;

  always_comb begin
    count_next = count_reg - 16'h0001;
    if (reload) begin
      count_next = divisor_after;
    end else if (tick) begin
      count_next = divisor_now;
    end
  end

  // prescaler phase advances on each divider tick
  always_comb begin
    phase_next = phase_reg;
    if (reload) begin
      phase_next = 7'h00;
    end else if (tick) begin
      if (phase_reg >= prescale - 7'h01) begin
        phase_next = 7'h00;
      end else begin
        phase_next = phase_reg + 7'h01;
      end
    end
  end

  // three strobes around mid-bit for the vote; one strobe at mid-bit when single sampling
  assign sample_strobe = tick && (single_sample ? (phase_reg == mid) :
                         ((phase_reg == mid - 7'h01) || (phase_reg == mid) ||
                          (phase_reg == mid + 7'h01)));
  assign last_strobe = tick && (phase_reg == (single_sample ? mid : mid + 7'h01));

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      count_reg <= 16'h0000;
      phase_reg <= 7'h00;
    end else begin
      count_reg <= count_next;
      phase_reg <= phase_next;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      transmit_status_control_reg <= `RESET_TRANSMIT_STATUS_CONTROL;
      receive_status_control_reg <= `RESET_RECEIVE_STATUS_CONTROL;
      baud_rate_control_reg <= `RESET_BAUD_RATE_CONTROL;
      divisor_high_byte_reg <= `RESET_BAUD_DIVISOR;
      divisor_low_byte_reg <= `RESET_BAUD_DIVISOR;
    end else begin
      // read-only and unimplemented bits keep their fixed values
      if (wr_tx) begin
        transmit_status_control_reg <= (reg_req_i.wdata & `MASK_TRANSMIT_STATUS_CONTROL) |
                                       `RESET_TRANSMIT_STATUS_CONTROL;
      end
      if (wr_rx) begin
        receive_status_control_reg <= reg_req_i.wdata & `MASK_RECEIVE_STATUS_CONTROL;
      end
      if (wr_baud) begin
        baud_rate_control_reg <= (reg_req_i.wdata & `MASK_BAUD_RATE_CONTROL) |
                                 `RESET_BAUD_RATE_CONTROL;
      end
      if (wr_high) begin
        divisor_high_byte_reg <= reg_req_i.wdata;
      end
      if (wr_low) begin
        divisor_low_byte_reg <= reg_req_i.wdata;
      end
    end
  end

  rx_sampler rx_sampler_inst (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .rx_pin_i(rx_pin_i),
    .sample_i(sample_strobe),
    .last_i(last_strobe),
    .single_i(single_sample),
    .rx_bit_o(rx_bit_o)
  );

  assign status_word = {6'h00, single_sample, rx_bit_o.level};

  assign read_mux =
    (reg_req_i.addr == `ADDR_TRANSMIT_STATUS_CONTROL) ? transmit_status_control_reg :
    (reg_req_i.addr == `ADDR_RECEIVE_STATUS_CONTROL) ? receive_status_control_reg :
    (reg_req_i.addr == `ADDR_BAUD_RATE_CONTROL) ? baud_rate_control_reg :
    (reg_req_i.addr == `ADDR_BAUD_DIVISOR_HIGH) ? divisor_high_byte_reg :
    (reg_req_i.addr == `ADDR_BAUD_DIVISOR_LOW) ? divisor_low_byte_reg :
    (reg_req_i.addr == `ADDR_SAMPLER_STATUS) ? status_word :
    8'h00;

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= reg_req_i.read ? read_mux : 8'h00;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign divider_tick_o = tick;
  // bit rate is the last prescale phase
  assign bit_tick_o = tick && (phase_reg >= prescale - 7'h01);
  assign clocked_mode_o = clocked_mode_select;
  assign serial_enable_o = receive_status_control_reg[`BIT_SERIAL_PORT_ENABLE];

endmodule

/* File: sim/baud_gen_assertions.sv */
// port-level checks for the baud generator
`timescale 1ns/1ps
module baud_gen_assertions
  import baud_gen_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  input reg_req_s reg_req_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic rx_pin_i,
  input wire logic divider_tick_o,
  input wire logic bit_tick_o,
  input wire logic clocked_mode_o,
  input wire logic serial_enable_o,
  input rx_bit_s rx_bit_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // a reload restarts the prescale phase, so no bit tick can follow within three cycles
  reload_phase_a: assert property (reg_req_i.write && (reg_req_i.addr == 3'h3 ||
    reg_req_i.addr == 3'h4) |=> !bit_tick_o [*3]) else $error("bit tick too soon after reload");
  // prescale is never below four ticks
  bit_spacing_a: assert property (bit_tick_o |=> !bit_tick_o [*3])
    else $error("bit ticks too close");
  mode_follow_a: assert property (reg_req_i.write && reg_req_i.addr == 3'h0
    |=> clocked_mode_o == $past(reg_req_i.wdata[4])) else $error("mode bit lost");
  div_readback_a: assert property (reg_req_i.write && reg_req_i.addr == 3'h3
    ##2 reg_req_i.read && reg_req_i.addr == 3'h3 |=> reg_rdata_o == $past(reg_req_i.wdata, 3))
    else $error("divisor high readback wrong");
  wide_readback_a: assert property (reg_req_i.write && reg_req_i.addr == 3'h2
    ##2 reg_req_i.read && reg_req_i.addr == 3'h2 |=> reg_rdata_o[3] == $past(reg_req_i.wdata[3], 3))
    else $error("wide select readback wrong");
  single_status_a: assert property (reg_req_i.read && reg_req_i.addr == 3'h5
    && clocked_mode_o |=> reg_rdata_o[1]) else $error("single mode not shown");
  valid_spacing_a: assert property ($rose(rx_bit_o.valid) |=> !rx_bit_o.valid [*2])
    else $error("sample results too close");
  reload_now_a: assert property (reg_req_i.write && reg_req_i.addr == 3'h4
    && reg_req_i.wdata == 8'h03 |=> !divider_tick_o [*3] ##1 divider_tick_o)
    else $error("divisor write did not reload");
endmodule

/* File: sim/line_partner_model.sv */
// far-end transmitter: idles the line high and places timed glitches
`timescale 1ns/1ps
module line_partner_model (
  input wire logic clock_i,
  input wire logic bit_tick_i,
  output logic line_o
);
  initial line_o = 1'b1;
  // one-cycle glitch
  // second boundary is used since the first may follow a phase wrap
  task automatic glitch(input int off);
    repeat (2) do @(negedge clock_i); while (bit_tick_i !== 1'b1);
    repeat (off) @(posedge clock_i);
    line_o <= ~line_o;
    @(posedge clock_i);
    line_o <= ~line_o;
  endtask
endmodule

/* File: sim/serial_baud_rate_generator_test.sv */
// testbench for the baud tick divider and receive sampling
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module serial_baud_rate_generator_test import baud_gen_pkg::*;;
  logic clock_i, reset_i, rx_pin_i, divider_tick_o, bit_tick_o, clocked_mode_o, serial_enable_o;
  reg_req_s reg_req_i;
  logic [7:0] reg_rdata_o;
  rx_bit_s rx_bit_o;
  int error_cnt = 0, total_checks = 0, cycles = 0;
  // tx, baud, high, low
  localparam logic [31:0] CFG [7] = '{32'h00000102, 32'h04000102, 32'h00080002,
    32'h04080002, 32'h10000002, 32'h14080002, 32'h00080100};
  localparam int BITP [7] = '{192, 48, 48, 12, 12, 12, 4112};
  localparam real CLK_HZ = 100.0e6;
  serial_baud_rate_generator serial_baud_rate_generator_inst (.clock_i(clock_i),
    .reset_i(reset_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o), .rx_pin_i(rx_pin_i),
    .divider_tick_o(divider_tick_o), .bit_tick_o(bit_tick_o), .clocked_mode_o(clocked_mode_o),
    .serial_enable_o(serial_enable_o), .rx_bit_o(rx_bit_o));
  line_partner_model line_partner_model_inst (.clock_i(clock_i), .bit_tick_i(bit_tick_o),
    .line_o(rx_pin_i));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 60000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_req_i <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
    @(posedge clock_i);
    reg_req_i.write <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clock_i);
    reg_req_i <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock_i);
    reg_req_i.read <= 1'b0;
    @(negedge clock_i);
    `CHK(reg_rdata_o, e)
  endtask
  // measures the second of two tick intervals, second to third tick, so a mode change settles first
  task automatic period(input logic b, input int e);
    int k;
    k = 0;
    repeat (2) do @(negedge clock_i); while ((b ? bit_tick_o : divider_tick_o) !== 1'b1);
    do begin @(negedge clock_i); k++; end while ((b ? bit_tick_o : divider_tick_o) !== 1'b1);
    `CHK(k, e)
  endtask
  task automatic regs_test;
    logic [2:0] a [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    logic [7:0] e [6] = '{8'hff, 8'hf8, 8'hfb, 8'hff, 8'hff, 8'h00};
    logic [7:0] r [6] = '{8'h02, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++) rd(a[i], r[i]);
    for (int i = 0; i < 6; i++) begin
      wr(a[i], 8'hff);
      rd(a[i], e[i]);
    end
    `CHK(clocked_mode_o, 1'b1)
    for (int i = 0; i < 6; i++) wr(a[i], 8'h00);
  endtask
  task automatic rates_test;
    int n;
    for (int i = 0; i < 7; i++) begin
      wr(3'h0, CFG[i][31:24]);
      wr(3'h2, CFG[i][23:16]);
      wr(3'h3, CFG[i][15:8]);
      wr(3'h4, CFG[i][7:0]);
      n = CFG[i][19] ? int'(CFG[i][15:0]) : int'(CFG[i][7:0]);
      period(1'b0, n + 1);
      period(1'b1, BITP[i]);
    end
    // software side: divisor recomputed from the present clock for a target rate, rounded
    n = int'(CLK_HZ / 400000.0 / 64.0 - 1.0);
    wr(3'h0, 8'h00);
    wr(3'h2, 8'h00);
    wr(3'h4, n[7:0]);
    period(1'b1, 64 * (n + 1));
  endtask
  task automatic reload_test;
    int k;
    wr(3'h0, 8'h00);
    wr(3'h2, 8'h00);
    wr(3'h3, 8'h00);
    wr(3'h4, 8'hc8);
    repeat (50) @(posedge clock_i);
    for (int j = 0; j < 3; j++) begin
      wr(j == 2 ? 3'h3 : 3'h4, j == 2 ? 8'h00 : 8'h03);
      k = 0;
      do begin @(negedge clock_i); k++; end while (divider_tick_o !== 1'b1);
      `CHK(k, 4)
    end
  endtask
  task automatic sample(input logic [7:0] tx, input logic [7:0] bd, input int off,
    input logic e);
    int k;
    wr(3'h0, tx);
    wr(3'h2, bd);
    line_partner_model_inst.glitch(off);
    k = 0;
    do begin @(negedge clock_i); k++; end while (rx_bit_o.valid !== 1'b1 && k < 40);
    `CHK(rx_bit_o.valid, 1'b1)
    `CHK(rx_bit_o.level, e)
  endtask
  task automatic sample_test;
    wr(3'h1, 8'h80);
    wr(3'h4, 8'h00);
    `CHK(serial_enable_o, 1'b1)
    sample(8'h04, 8'h00, 7, 1'b1);
    rd(3'h5, 8'h01);
    sample(8'h10, 8'h00, 1, 1'b0);
    rd(3'h5, 8'h02);
    sample(8'h04, 8'h08, 1, 1'b0);
  endtask
  initial begin
    reset_i = 1'b1;
    reg_req_i = '0;
    repeat (12) @(posedge clock_i);
    reset_i <= 1'b0;
    regs_test();
    rates_test();
    reload_test();
    sample_test();
    finish_test();
  end
endmodule
bind serial_baud_rate_generator baud_gen_assertions baud_gen_assertions_inst (
  .clock_i(clock_i), .reset_i(reset_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
  .rx_pin_i(rx_pin_i), .divider_tick_o(divider_tick_o), .bit_tick_o(bit_tick_o),
  .clocked_mode_o(clocked_mode_o), .serial_enable_o(serial_enable_o), .rx_bit_o(rx_bit_o));
